// ==== logic/dmp_pkg.sv ====
// package for the dual modulus prescaler: divisor constants and carrier types
// assumes a single 250 MHz clock domain; no registers reachable by software
package dmp_pkg;

  localparam int unsigned DMP_CNT_W = 8;
  localparam logic [DMP_CNT_W-1:0] DMP_DIV_LOW_PAIR = 8'h40;
  localparam logic [DMP_CNT_W-1:0] DMP_DIV_HIGH_PAIR = 8'h80;
  localparam logic [DMP_CNT_W-1:0] DMP_CNT_RST = 8'h00;
  localparam logic [DMP_CNT_W-1:0] DMP_CNT_ONE = 8'h01;

  // output polarity variant
  typedef enum logic [0:0] {
    DMP_EDGE_POS = 1'b0,
    DMP_EDGE_NEG = 1'b1
  } dmp_edge_t;

  // synchronised control inputs
  typedef struct packed {
    logic range_sel;
    logic mod_sel;
  } dmp_ctrl_t;

endpackage : dmp_pkg

// ==== logic/dmp_prescaler.sv ====
// dual modulus prescaler: one output cycle every N clock cycles, N in 64/65/128/129
// assumes control inputs arrive asynchronously from synthesizer logic
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - range select high picks the 64/65 pair, low picks the 128/129 pair.
// - modulus select high divides by the small modulus, low by that modulus plus one.
// - the positive-edge variant starts each output period with a rising edge.
// - the negative-edge variant starts each output period with a falling edge.
module dmp_prescaler
  import dmp_pkg::*;
#(
  parameter dmp_edge_t EDGE_VARIANT = DMP_EDGE_POS
)
(
  input wire logic clk,
  input wire logic srst,
  input wire logic ratio_range_select,
  input wire logic modulus_select_in,
  output logic div_out,
  output logic period_start
);

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers

  dmp_ctrl_t ctrl_meta;
  dmp_ctrl_t ctrl_sync;

  // first stage may go metastable; only the second stage is read by logic
  always_ff @(posedge clk)
  begin
    ctrl_meta <= '{range_sel: ratio_range_select, mod_sel: modulus_select_in};
  end

  // second stage: the only copy of the controls seen by the divider
  always_ff @(posedge clk)
  begin
    ctrl_sync <= ctrl_meta;
  end

  ////////////////////////////////////////////////////////////////////////////
  // divisor selection

  function automatic logic [DMP_CNT_W-1:0] divisor(input dmp_ctrl_t c);
    logic [DMP_CNT_W-1:0] base;
    base = c.range_sel ? DMP_DIV_LOW_PAIR : DMP_DIV_HIGH_PAIR;
    return c.mod_sel ? base : base + DMP_CNT_ONE;
  endfunction : divisor

  logic [DMP_CNT_W-1:0] cnt;
  logic [DMP_CNT_W-1:0] period_len;
  logic last_cycle;
  logic half_high;
  logic [DMP_CNT_W-1:0] half_len;

  assign last_cycle = (cnt == period_len - DMP_CNT_ONE);

  // latched at the period boundary so a late change cannot stretch the current cycle
  always_ff @(posedge clk)
  begin
    if (srst)
      period_len <= DMP_DIV_HIGH_PAIR + DMP_CNT_ONE;
    else if (last_cycle)
      period_len <= divisor(ctrl_sync);
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      cnt <= DMP_CNT_RST;
    else if (last_cycle)
      cnt <= DMP_CNT_RST;
    else
      cnt <= cnt + DMP_CNT_ONE;
  end

  ////////////////////////////////////////////////////////////////////////////
  // output shaping

  // first half of the period active; odd moduli give the extra cycle to the inactive second half (low for the positive variant, high for the negative)
  // active half is the rounded-down half of the period
  assign half_len = {1'b0, period_len[DMP_CNT_W-1:1]};
  assign half_high = (cnt < half_len);

  always_ff @(posedge clk)
  begin
    if (srst)
      div_out <= (EDGE_VARIANT == DMP_EDGE_NEG);
    else if (EDGE_VARIANT == DMP_EDGE_POS)
      div_out <= half_high;
    else
      div_out <= ~half_high;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      period_start <= 1'b0;
    else
      period_start <= (cnt == DMP_CNT_RST);
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  // the checks watch the counter, the latched modulus and both outputs;
  // they say nothing about the synchroniser delay, which is left to the bench

  sequence s_boundary;
    last_cycle;
  endsequence

  sequence s_period_open;
    period_start;
  endsequence

  sequence s_half_point;
    cnt == half_len;
  endsequence

  sequence s_reset_release;
    srst ##1 !srst;
  endsequence

  a_len_follows_ctrl: assert property (@(posedge clk) disable iff (srst)
    s_boundary |=> period_len == divisor($past(ctrl_sync)))
    else $error("period length not taken from sampled control");

  a_len_legal: assert property (@(posedge clk) disable iff (srst)
    period_len == DMP_DIV_LOW_PAIR ||
    period_len == DMP_DIV_LOW_PAIR + DMP_CNT_ONE ||
    period_len == DMP_DIV_HIGH_PAIR ||
    period_len == DMP_DIV_HIGH_PAIR + DMP_CNT_ONE)
    else $error("illegal modulus");

  a_range_high_pair: assert property (@(posedge clk) disable iff (srst)
    last_cycle && ctrl_sync.range_sel |=>
      period_len == DMP_DIV_LOW_PAIR || period_len == DMP_DIV_LOW_PAIR + DMP_CNT_ONE)
    else $error("range select high did not give the small pair");

  a_range_low_pair: assert property (@(posedge clk) disable iff (srst)
    last_cycle && !ctrl_sync.range_sel |=>
      period_len == DMP_DIV_HIGH_PAIR || period_len == DMP_DIV_HIGH_PAIR + DMP_CNT_ONE)
    else $error("range select low did not give the large pair");

  a_cnt_wrap: assert property (@(posedge clk) disable iff (srst)
    s_boundary |=> cnt == DMP_CNT_RST)
    else $error("counter did not wrap at period end");

  a_cnt_bound: assert property (@(posedge clk) disable iff (srst)
    cnt < period_len)
    else $error("counter ran past the period length");

  a_pulse_single: assert property (@(posedge clk) disable iff (srst)
    s_period_open |=> !period_start)
    else $error("period start pulse longer than one cycle");

  a_len_stable: assert property (@(posedge clk) disable iff (srst)
    !last_cycle |=> $stable(period_len))
    else $error("modulus changed mid period");

  a_mod_plus_one: assert property (@(posedge clk) disable iff (srst)
    last_cycle && !ctrl_sync.mod_sel |=> period_len[0])
    else $error("low modulus select did not add one");

  a_start_edge_pos: assert property (@(posedge clk) disable iff (srst)
    EDGE_VARIANT == DMP_EDGE_POS && period_start |-> div_out && !$past(div_out))
    else $error("rising edge missing at period start");

  a_start_edge_neg: assert property (@(posedge clk) disable iff (srst)
    EDGE_VARIANT == DMP_EDGE_NEG && period_start |-> !div_out && $past(div_out))
    else $error("falling edge missing at period start");

  // the opposite edge lands exactly at the half point, odd moduli included
  a_half_edge_pos: assert property (@(posedge clk) disable iff (srst)
    s_half_point |=> (EDGE_VARIANT == DMP_EDGE_NEG) || (!div_out && $past(div_out)))
    else $error("positive variant missed its mid period fall");

  a_half_edge_neg: assert property (@(posedge clk) disable iff (srst)
    s_half_point |=> (EDGE_VARIANT == DMP_EDGE_POS) || (div_out && !$past(div_out)))
    else $error("negative variant missed its mid period rise");

  // reset is checked without the disable, so no guard here
  a_reset_idle: assert property (@(posedge clk)
    srst |=> !period_start && div_out == (EDGE_VARIANT == DMP_EDGE_NEG) &&
      period_len == DMP_DIV_HIGH_PAIR + DMP_CNT_ONE)
    else $error("outputs not idle during reset");

  a_start_after_reset: assert property (@(posedge clk)
    s_reset_release |=> period_start)
    else $error("first period did not open after reset");

endmodule : dmp_prescaler

`default_nettype wire

// ==== testbench/dmp_synth_model.sv ====
// swallow counter stand-in driving modulus select
// assumes period_start pulses once per output period
`timescale 1ns/1ps
`default_nettype none
module dmp_synth_model(
  input wire logic clk,
  input wire logic srst,
  input wire logic period_start,
  input wire logic use_model,
  input wire logic mod_sel_manual,
  output logic mod_sel
);
  // alternates small and large modulus each period, like a swallow counter
  logic phase;
  always_ff @(posedge clk)
  begin
    if (srst) phase <= 1'b0;
    else if (period_start) phase <= ~phase;
  end
  assign mod_sel = use_model ? phase : mod_sel_manual;
endmodule : dmp_synth_model
`default_nettype wire

// ==== testbench/tb.sv ====
// self-checking bench for dmp_prescaler
// assumes 250 MHz clock, synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dmp_pkg::*;
  logic clk = 0, srst = 1, range_sel = 1, mod_sel_b = 1, use_model = 0, mod_sel, div_out, div_n, period_start;
  int num_errors = 0, n_checks = 0, n, h, a;
  int rows[4][3] = '{'{1, 1, 64}, '{1, 0, 65}, '{0, 1, 128}, '{0, 0, 129}};
  always #2 clk = ~clk;
  dmp_prescaler dut(.clk(clk), .srst(srst), .ratio_range_select(range_sel), .modulus_select_in(mod_sel),
    .div_out(div_out), .period_start(period_start));
  dmp_prescaler #(.EDGE_VARIANT(DMP_EDGE_NEG)) dut_n(.clk(clk), .srst(srst), .ratio_range_select(range_sel),
    .modulus_select_in(mod_sel), .div_out(div_n), .period_start());
  dmp_synth_model peer(.clk(clk), .srst(srst), .period_start(period_start), .use_model(use_model),
    .mod_sel_manual(mod_sel_b), .mod_sel(mod_sel));
  task chk(string what, logic [8:0] exp, logic [8:0] got);
    n_checks++;
    if (exp !== got)
    begin
      num_errors++;
      $display("wrong value %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk
  // counts cycles up to the next period start
  task per();
    n = 0;
    h = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
      h += (div_out === 1'b1);
    end while (period_start !== 1'b1 && n < 300);
  endtask : per
  task complete_run();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run
  initial
  begin
    repeat (3) @(posedge clk);
    srst <= 0;
    #1;
    chk("div_out in reset", 0, div_out);
    chk("neg div_out in reset", 1, div_n);
    per();
    foreach (rows[i])
    begin
      @(posedge clk);
      range_sel <= rows[i][0];
      mod_sel_b <= rows[i][1];
      per();
      per();
      chk("period", rows[i][2], n);
      chk("active cycles", rows[i][2] / 2, h);
      chk("neg level at start", 0, div_n);
    end
    @(posedge clk);
    range_sel <= 1;
    use_model <= 1;
    per();
    per();
    per();
    a = n;
    per();
    chk("swallow pair", 129, a + n);
    chk("swallow step", 1, a > n ? a - n : n - a);
    // change mid period must wait for the next boundary
    @(posedge clk);
    use_model <= 0;
    mod_sel_b <= 1;
    per();
    per();
    repeat (10) @(posedge clk);
    mod_sel_b <= 0;
    per();
    chk("held period", 64 - 10, n);
    per();
    chk("next period", 65, n);
    // reset in mid run
    repeat (5) @(posedge clk);
    srst <= 1;
    repeat (3) @(posedge clk);
    srst <= 0;
    #1;
    chk("start in reset", 0, period_start);
    chk("div_out mid reset", 0, div_out);
    chk("neg div_out mid reset", 1, div_n);
    per();
    chk("first start after reset", 1, n);
    per();
    chk("period after reset", 129, n);
    complete_run();
  end
  initial
  begin
    #40000;
    num_errors++;
    complete_run();
  end
endmodule : tb
`default_nettype wire
